// *** serial_master_pkg.sv ***
// constants, types and register map of the two-wire master transmitter
// assumes a 10 MHz system clock and a plain address/strobe register port
package serial_master_pkg;

    // register indices on the software port
    localparam logic [1:0] CTRL_IDX   = 2'h0;
    localparam logic [1:0] STATUS_IDX = 2'h1;
    localparam logic [1:0] DATA_IDX   = 2'h2;

    // control register bit positions
    localparam int FLAG_POS  = 7;
    localparam int ACK_POS   = 6;
    localparam int START_POS = 5;
    localparam int STOP_POS  = 4;
    localparam int WC_POS    = 3;
    localparam int EN_POS    = 2;

    // status codes, prescaler bits zero
    localparam logic [7:0] SC_START   = 8'h08;
    localparam logic [7:0] SC_RESTART = 8'h10;
    localparam logic [7:0] SC_AW_ACK  = 8'h18;
    localparam logic [7:0] SC_AW_NACK = 8'h20;
    localparam logic [7:0] SC_D_ACK   = 8'h28;
    localparam logic [7:0] SC_D_NACK  = 8'h30;
    localparam logic [7:0] SC_LOST    = 8'h38;
    localparam logic [7:0] SC_AR_ACK  = 8'h40;
    localparam logic [7:0] SC_AR_NACK = 8'h48;
    localparam logic [7:0] SC_NONE    = 8'hF8;
    localparam logic [7:0] STATUS_RST = 8'hF8;
    localparam logic [7:0] DATA_RST   = 8'hFF;

    // bus timing: quarter of a 100 kHz bit, least time, rounded up
    localparam int CLK_NS       = 100;
    localparam int QUARTER_NS   = 2500;
    localparam int QUARTER_CYC  = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int BYTE_BITS    = 8;

    // phase numbers within one bit
    localparam logic [1:0] PH_SETUP = 2'h0;
    localparam logic [1:0] PH_RISE  = 2'h1;
    localparam logic [1:0] PH_HIGH  = 2'h2;
    localparam logic [1:0] PH_FALL  = 2'h3;

    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b000,
        ENG_START = 3'b001,
        ENG_BYTE  = 3'b010,
        ENG_ACK   = 3'b011,
        ENG_HOLD  = 3'b100,
        ENG_STOP  = 3'b101
    } engine_state_type;

    // control register as seen by software
    typedef struct packed {
        logic       flag;
        logic       ack_enable_bit;
        logic       start;
        logic       stop;
        logic       write_collision_bit;
        logic       enable;
        logic [1:0] unused;
    } ctrl_type;

    // synchronised bus line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } lines_type;

endpackage : serial_master_pkg

// *** slave_receiver_model.sv ***
// partner model: slave receiver on the two-wire bus
// assumes open-drain lines resolved by the bench with pull-ups
`timescale 1ns/1ns
`default_nettype none
module slave_receiver_model #(
    parameter logic [6:0] OWN_ADDR = 7'h28
) (
    input  wire logic       scl_in,       // resolved clock line
    input  wire logic       sda_in,       // resolved data line
    input  wire logic       nack_data_in, // refuse data bytes
    output logic            sda_oe_out,   // pull data line low
    output logic      [7:0] byte_out,     // last byte taken
    output logic      [3:0] starts_out,   // start conditions seen
    output logic      [3:0] stops_out     // stop conditions seen
);
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       first;
    logic       in_ack;
    logic       framed;
    initial begin
        framed     = 1'b0;
        sda_oe_out = 1'b0;
        starts_out = 4'h0;
        stops_out  = 4'h0;
        bit_cnt    = 4'h0;
        in_ack     = 1'b0;
        first      = 1'b0;
    end
    // data line moving while clock high frames a transfer
    always @(negedge sda_in) if (scl_in) begin
        starts_out = starts_out + 4'h1;
        bit_cnt    = 4'h0;
        first      = 1'b1;
        in_ack     = 1'b0;
        framed     = 1'b1;
    end
    // a stop counts only inside a frame, so lines leaving reset are not one
    always @(posedge sda_in) if (scl_in && framed) begin
        stops_out = stops_out + 4'h1;
        framed    = 1'b0;
    end
    // sample on clock rise, msb first
    always @(posedge scl_in) if (bit_cnt < 4'h8) begin
        shift   = {shift[6:0], sda_in};
        bit_cnt = bit_cnt + 4'h1;
    end
    // ack only while clock low so it never looks like start or stop
    always @(negedge scl_in) begin
        if (in_ack) begin
            sda_oe_out = 1'b0;
            in_ack     = 1'b0;
            bit_cnt    = 4'h0;
            first      = 1'b0;
        end else if (bit_cnt == 4'h8) begin
            byte_out   = shift;
            in_ack     = 1'b1;
            sda_oe_out = first ? (shift[7:1] == OWN_ADDR) : !nack_data_in;
        end
    end
endmodule : slave_receiver_model
`default_nettype wire

// *** sync_two_flop.sv ***
// two flip-flop synchroniser for a vector of independent levels
// assumes the inputs are quasi-static compared to the clock
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input  wire logic             clock_in,   // system clock
    input  wire logic             resetn_in,  // async reset, active low
    input  wire logic [WIDTH-1:0] async_in,   // levels from outside
    output logic      [WIDTH-1:0] sync_out    // levels in clock domain
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_ff  <= INIT;
            sync_out <= INIT;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : sync_two_flop
`default_nettype wire

// *** two_wire_master_transmitter.sv ***
// master transmitter of a byte-oriented two-wire serial interface
// assumes open-drain bus lines resolved outside, pulled up when released
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_transmitter
    import serial_master_pkg::*;
#(
    parameter int QUARTER_CYCLES = QUARTER_CYC
) (
    input  wire logic       clock_in,   // system clock, 10 MHz
    input  wire logic       resetn_in,  // async reset, active low
    input  wire logic [1:0] addr_in,    // register index
    input  wire logic [7:0] wdata_in,   // write data
    input  wire logic       wr_in,      // write strobe
    input  wire logic       rd_in,      // read strobe
    output logic      [7:0] rdata_out,  // read data, cycle after strobe
    input  wire logic       scl_in,     // clock line level
    output logic            scl_out,    // clock line drive level
    output logic            scl_oe_out, // clock line pulled low
    input  wire logic       sda_in,     // data line level
    output logic            sda_out,    // data line drive level
    output logic            sda_oe_out  // data line pulled low
);
    // the stretch check and the synchroniser need two cycles per quarter
    if (QUARTER_CYCLES < 2) begin : g_quarter_check
        $error("QUARTER_CYCLES must be at least 2");
    end

    localparam int DIV_W = $clog2(QUARTER_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QUARTER_CYCLES - 1);

    engine_state_type state_ff, nxt_state;
    ctrl_type         ctrl_ff;
    lines_type        lines_s, lines_prev_ff;
    logic [7:0]       status_ff, nxt_status, data_ff, shift_ff, nxt_shift;
    logic [1:0]       presc_ff, phase_ff, nxt_phase;
    logic [2:0]       bit_cnt_ff, nxt_bit_cnt;
    logic [DIV_W-1:0] div_ff;
    logic             tick_ff, busy_ff, is_addr_ff, nxt_is_addr, rw_ff, nxt_rw;
    logic             recv_mode_ff, nxt_recv_mode, restart_ff, nxt_restart;
    logic             flag_set, stop_done, lost;

    sync_two_flop #(.WIDTH(2), .INIT(2'b11)) u_sync (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .async_in  ({scl_in, sda_in}),
        .sync_out  (lines_s)
    );

    // register port decode
    wire wr_ctrl   = wr_in && (addr_in == CTRL_IDX);
    wire wr_status = wr_in && (addr_in == STATUS_IDX);
    wire wr_data   = wr_in && (addr_in == DATA_IDX);
    wire ctrl_type wr_ctrl_val = wdata_in;
    wire [7:0] ctrl_rd   = {ctrl_ff[7:2], 2'b00};
    wire [7:0] status_rd = {status_ff[7:3], 1'b0, presc_ff};
    wire [7:0] rd_mux = (addr_in == CTRL_IDX)   ? ctrl_rd :
                        (addr_in == STATUS_IDX) ? status_rd :
                        (addr_in == DATA_IDX)   ? data_ff : 8'h00;

    // bus condition detection on the synchronised lines
    wire bus_start_seen = lines_prev_ff.sda && !lines_s.sda && lines_s.scl;
    wire bus_stop_seen  = !lines_prev_ff.sda && lines_s.sda && lines_s.scl;
    // a slave holding the clock low stretches the high phase
    wire step = tick_ff && !(phase_ff == PH_HIGH && !lines_s.scl);
    wire go   = ctrl_ff.enable;

    // quarter-bit enable divider
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= (div_ff == DIV_LAST) ? '0 : div_ff + 1'b1;
            tick_ff <= (div_ff == DIV_LAST);
        end
    end

    // bus busy between any START and STOP on the wires
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lines_prev_ff <= 2'b11;
            busy_ff       <= 1'b0;
        end else begin
            lines_prev_ff <= lines_s;
            if (bus_start_seen)
                busy_ff <= 1'b1;
            else if (bus_stop_seen)
                busy_ff <= 1'b0;
        end
    end

    // engine next state; pins change only on quarter-bit steps, except the release at once on disable
    always_comb begin
        nxt_state     = state_ff;
        nxt_phase     = phase_ff;
        nxt_status    = status_ff;
        nxt_shift     = shift_ff;
        nxt_bit_cnt   = bit_cnt_ff;
        nxt_is_addr   = is_addr_ff;
        nxt_rw        = rw_ff;
        nxt_recv_mode = recv_mode_ff;
        nxt_restart   = restart_ff;
        flag_set      = 1'b0;
        stop_done     = 1'b0;
        lost          = 1'b0;
        case (state_ff)
            ENG_IDLE: begin
                // waits for a free bus; flag must be cleared first
                if (go && ctrl_ff.start && !ctrl_ff.flag && !busy_ff && step) begin
                    nxt_state   = ENG_START;
                    nxt_phase   = PH_SETUP;
                    nxt_restart = 1'b0;
                end
            end
            ENG_START: begin
                if (step) begin
                    nxt_phase = phase_ff + 2'd1;
                    if (phase_ff == PH_FALL) begin
                        flag_set    = 1'b1;
                        nxt_status  = restart_ff ? SC_RESTART : SC_START;
                        nxt_is_addr = 1'b1;
                        nxt_state   = ENG_HOLD;
                    end
                end
            end
            ENG_HOLD: begin
                // one bus action per cleared flag; ack enable is not looked at
                if (!ctrl_ff.flag) begin
                    nxt_phase = PH_SETUP;
                    if (ctrl_ff.stop) begin
                        nxt_state = ENG_STOP;
                    end else if (ctrl_ff.start) begin
                        nxt_state   = ENG_START;
                        nxt_restart = 1'b1;
                    end else if (recv_mode_ff) begin
                        // receiving belongs to another block; report again
                        flag_set = 1'b1;
                    end else begin
                        nxt_state   = ENG_BYTE;
                        nxt_shift   = data_ff;
                        nxt_rw      = is_addr_ff ? data_ff[0] : rw_ff;
                        nxt_bit_cnt = 3'(BYTE_BITS - 1);
                    end
                end
            end
            ENG_BYTE: begin
                if (step) begin
                    nxt_phase = phase_ff + 2'd1;
                    // released one read back as zero: another master won
                    if (phase_ff == PH_HIGH && shift_ff[7] && !lines_s.sda) begin
                        lost        = 1'b1;
                        flag_set    = 1'b1;
                        nxt_status  = SC_LOST;
                        nxt_state   = ENG_IDLE;
                        nxt_is_addr = 1'b0;
                    end else if (phase_ff == PH_FALL) begin
                        nxt_shift   = {shift_ff[6:0], 1'b0};
                        nxt_bit_cnt = bit_cnt_ff - 3'd1;
                        if (bit_cnt_ff == 3'd0)
                            nxt_state = ENG_ACK;
                    end
                end
            end
            ENG_ACK: begin
                if (step) begin
                    nxt_phase = phase_ff + 2'd1;
                    if (phase_ff == PH_FALL) begin
                        flag_set    = 1'b1;
                        nxt_state   = ENG_HOLD;
                        nxt_is_addr = 1'b0;
                        // status picked from sampled ack held in shift bit 0
                        if (is_addr_ff && rw_ff) begin
                            nxt_recv_mode = 1'b1;
                            nxt_status    = shift_ff[0] ? SC_AR_NACK : SC_AR_ACK;
                        end else if (is_addr_ff) begin
                            nxt_recv_mode = 1'b0;
                            nxt_status    = shift_ff[0] ? SC_AW_NACK : SC_AW_ACK;
                        end else begin
                            nxt_status = shift_ff[0] ? SC_D_NACK : SC_D_ACK;
                        end
                    end else if (phase_ff == PH_HIGH) begin
                        nxt_shift = {7'h00, lines_s.sda};
                    end
                end
            end
            ENG_STOP: begin
                if (step) begin
                    nxt_phase = phase_ff + 2'd1;
                    if (phase_ff == PH_FALL) begin
                        stop_done     = 1'b1;
                        nxt_status    = SC_NONE;
                        nxt_state     = ENG_IDLE;
                        nxt_recv_mode = 1'b0;
                    end
                end
            end
            default: begin
                nxt_state = ENG_IDLE;
            end
        endcase
    end

    // pin drive per state and phase: enable high pulls the line low
    wire drive_bit = (state_ff == ENG_BYTE) ? !shift_ff[7] : 1'b0;
    wire sda_next =
        (state_ff == ENG_START) ? ((phase_ff == PH_HIGH) || (phase_ff == PH_FALL)) :
        (state_ff == ENG_STOP)  ? (phase_ff != PH_HIGH) && (phase_ff != PH_FALL) :
        (state_ff == ENG_BYTE)  ? drive_bit :
        (state_ff == ENG_HOLD)  ? sda_oe_out : 1'b0;
    // clock stays low across every data line change outside the START and STOP states, which move data with clock high; so no false START or STOP
    wire scl_hold_low = (phase_ff == PH_SETUP) && scl_oe_out;
    wire scl_next =
        (state_ff == ENG_IDLE)  ? 1'b0 :
        (state_ff == ENG_HOLD)  ? 1'b1 :
        (state_ff == ENG_STOP)  ? (phase_ff == PH_SETUP) :
        (state_ff == ENG_START) ? (phase_ff == PH_FALL) || scl_hold_low :
        (phase_ff == PH_FALL) || (phase_ff == PH_SETUP);

    // engine registers
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff     <= ENG_IDLE;
            phase_ff     <= PH_SETUP;
            status_ff    <= STATUS_RST;
            shift_ff     <= '0;
            bit_cnt_ff   <= '0;
            is_addr_ff   <= 1'b0;
            rw_ff        <= 1'b0;
            recv_mode_ff <= 1'b0;
            restart_ff   <= 1'b0;
        end else if (!go) begin
            state_ff     <= ENG_IDLE;
            phase_ff     <= PH_SETUP;
            recv_mode_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            phase_ff     <= nxt_phase;
            status_ff    <= nxt_status;
            shift_ff     <= nxt_shift;
            bit_cnt_ff   <= nxt_bit_cnt;
            is_addr_ff   <= nxt_is_addr;
            rw_ff        <= nxt_rw;
            recv_mode_ff <= nxt_recv_mode;
            restart_ff   <= nxt_restart;
        end
    end

    // line drivers, updated on steps, released at once when disabled or lost
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (!go || lost) begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (step || state_ff == ENG_HOLD || state_ff == ENG_IDLE) begin
            scl_oe_out <= scl_next;
            sda_oe_out <= sda_next;
        end
    end

    // open-drain: the driven level is always low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // control register; hardware set of the flag beats a software clear
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff.ack_enable_bit <= wr_ctrl_val.ack_enable_bit;
                ctrl_ff.start          <= wr_ctrl_val.start;
                ctrl_ff.enable         <= wr_ctrl_val.enable;
            end
            if (flag_set)
                ctrl_ff.flag <= 1'b1;
            else if (wr_ctrl && wr_ctrl_val.flag)
                ctrl_ff.flag <= 1'b0;
            if (wr_ctrl)
                ctrl_ff.stop <= wr_ctrl_val.stop;
            else if (stop_done)
                ctrl_ff.stop <= 1'b0;
            if (wr_data)
                ctrl_ff.write_collision_bit <= !ctrl_ff.flag;
        end
    end

    // data and prescaler registers, read data
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_ff   <= DATA_RST;
            presc_ff  <= '0;
            rdata_out <= '0;
        end else begin
            if (wr_data && ctrl_ff.flag)
                data_ff <= wdata_in;
            if (wr_status)
                presc_ff <= wdata_in[1:0];
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    sequence start_end;
        state_ff == ENG_START && phase_ff == PH_FALL && step && go;
    endsequence
    sequence addr_ack_end;
        state_ff == ENG_ACK && phase_ff == PH_FALL && step && go && is_addr_ff;
    endsequence

    a_start_reported: assert property (start_end |=> ctrl_ff.flag &&
        (status_ff == SC_START || status_ff == SC_RESTART) && state_ff == ENG_HOLD)
        else $error("START not reported");
    a_restart_code: assert property (start_end and restart_ff |=>
        status_ff == SC_RESTART && scl_oe_out)
        else $error("repeated START code wrong");
    a_addr_write_code: assert property (addr_ack_end and !rw_ff |=>
        (status_ff == SC_AW_ACK || status_ff == SC_AW_NACK) && !recv_mode_ff)
        else $error("address write status wrong");
    a_addr_read_mode: assert property (addr_ack_end and rw_ff |=> recv_mode_ff)
        else $error("read address did not switch mode");
    a_collision_set: assert property (wr_data && !ctrl_ff.flag && !flag_set |=>
        ctrl_ff.write_collision_bit && $stable(data_ff))
        else $error("write collision not flagged");
    a_hold_stable: assert property (state_ff == ENG_HOLD && ctrl_ff.flag && go |=>
        $stable(status_ff) && scl_oe_out && state_ff == ENG_HOLD)
        else $error("suspended transfer moved");
    a_stop_clears: assert property (stop_done && !wr_ctrl |=> !ctrl_ff.stop
        ##1 !scl_oe_out && !sda_oe_out)
        else $error("STOP bit not cleared");
    a_lost_release: assert property (lost |=> status_ff == SC_LOST &&
        !scl_oe_out && !sda_oe_out && ctrl_ff.flag)
        else $error("lost arbitration not handled");
    a_data_code: assert property (state_ff == ENG_ACK && phase_ff == PH_FALL && step
        && go && !is_addr_ff |=> status_ff == SC_D_ACK || status_ff == SC_D_NACK)
        else $error("data status wrong");
    a_bit_level: assert property (state_ff == ENG_BYTE && phase_ff == PH_HIGH && go
        |-> sda_oe_out == !shift_ff[7])
        else $error("data line level wrong");
    a_one_action: assert property (state_ff == ENG_HOLD && !ctrl_ff.flag && go
        && !recv_mode_ff |=> state_ff != ENG_HOLD)
        else $error("cleared flag did not advance");

endmodule : two_wire_master_transmitter
`default_nettype wire

// *** two_wire_master_transmitter_tb_top.sv ***
// self-checking bench of the two-wire master transmitter
// assumes a pulled-up bus shared with the slave receiver model
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_transmitter_tb_top;
    import serial_master_pkg::*;
    logic       clock_in  = 1'b0;
    logic       resetn_in = 1'b0;
    logic [1:0] addr_in   = 2'h0;
    logic [7:0] wdata_in  = 8'h00;
    logic       wr_in     = 1'b0;
    logic       rd_in     = 1'b0;
    logic       nack_data = 1'b0;
    logic [7:0] rdata_out;
    logic       scl_oe_out;
    logic       sda_oe_out;
    logic       scl_drv;
    logic       sda_drv;
    logic       slave_oe;
    logic [7:0] slave_byte;
    logic [3:0] starts;
    logic [3:0] stops;
    wire logic  scl_line = ~scl_oe_out;
    wire logic  sda_line = ~(sda_oe_out | slave_oe);
    int         err_total = 0;
    int         compares  = 0;
    always #50 clock_in = ~clock_in;
    // short quarter for a quick run; the stretch check adds a quarter per bit
    two_wire_master_transmitter #(.QUARTER_CYCLES(2)) uut (
        .clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .scl_in(scl_line), .scl_out(scl_drv), .scl_oe_out(scl_oe_out),
        .sda_in(sda_line), .sda_out(sda_drv), .sda_oe_out(sda_oe_out));
    slave_receiver_model slave (
        .scl_in(scl_line), .sda_in(sda_line), .nack_data_in(nack_data),
        .sda_oe_out(slave_oe), .byte_out(slave_byte), .starts_out(starts),
        .stops_out(stops));
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_reg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v & m, exp);
    endtask : chk_reg
    // bounded poll so a lost flag fails instead of hanging
    task automatic wait_flag(input logic [7:0] code);
        logic [7:0] v;
        for (int i = 0; i < 500; i++) begin
            rd(CTRL_IDX, v);
            if (v[7] === 1'b1) break;
        end
        chk(v & 8'h80, 8'h80);
        chk_reg(STATUS_IDX, 8'hF8, code);
    endtask : wait_flag
    task automatic wait_stop();
        logic [7:0] v;
        for (int i = 0; i < 500; i++) begin
            rd(CTRL_IDX, v);
            if (v[4] === 1'b0) break;
        end
        chk(v & 8'h90, 8'h00);
        chk_reg(STATUS_IDX, 8'hF8, SC_NONE);
    endtask : wait_stop
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        #2_000_000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clock_in);
        resetn_in <= 1'b1;
        chk_reg(CTRL_IDX, 8'hFF, 8'h00);
        chk_reg(STATUS_IDX, 8'hFF, STATUS_RST);
        chk_reg(DATA_IDX, 8'hFF, DATA_RST);
        wr(2'h3, 8'h5A);
        chk_reg(2'h3, 8'hFF, 8'h00);
        wr(DATA_IDX, 8'h11);
        chk_reg(CTRL_IDX, 8'h08, 8'h08);
        chk_reg(DATA_IDX, 8'hFF, DATA_RST);
        chk({6'h00, scl_drv, sda_drv}, 8'h00);
        $display("test reset and collision done");
        wr(CTRL_IDX, 8'hA4);
        wait_flag(SC_START);
        wr(STATUS_IDX, 8'h03);
        chk_reg(STATUS_IDX, 8'hF8, SC_START);
        wr(DATA_IDX, 8'h50);
        chk_reg(CTRL_IDX, 8'h08, 8'h00);
        wr(CTRL_IDX, 8'hC4);
        wait_flag(SC_AW_ACK);
        chk(slave_byte, 8'h50);
        repeat (4) begin
            @(posedge clock_in);
            #1 chk({6'h00, scl_oe_out, sda_oe_out}, 8'h02);
        end
        wr(DATA_IDX, 8'hA5);
        wr(CTRL_IDX, 8'h84);
        wait_flag(SC_D_ACK);
        chk(slave_byte, 8'hA5);
        nack_data <= 1'b1;
        wr(DATA_IDX, 8'h3C);
        wr(CTRL_IDX, 8'h84);
        wait_flag(SC_D_NACK);
        nack_data <= 1'b0;
        $display("test write transfer done");
        wr(CTRL_IDX, 8'hA4);
        wait_flag(SC_RESTART);
        wr(DATA_IDX, 8'h62);
        wr(CTRL_IDX, 8'h84);
        wait_flag(SC_AW_NACK);
        wr(CTRL_IDX, 8'h94);
        wait_stop();
        chk({starts, stops}, 8'h21);
        $display("test restart and stop done");
        wr(CTRL_IDX, 8'hA4);
        wait_flag(SC_START);
        wr(DATA_IDX, 8'h50);
        wr(CTRL_IDX, 8'h84);
        wait_flag(SC_AW_ACK);
        wr(CTRL_IDX, 8'hB4);
        wait_flag(SC_START);
        chk({starts, stops}, 8'h42);
        chk_reg(CTRL_IDX, 8'h10, 8'h00);
        wr(DATA_IDX, 8'h51);
        wr(CTRL_IDX, 8'h84);
        wait_flag(SC_AR_ACK);
        wr(CTRL_IDX, 8'h94);
        wait_stop();
        $display("test stop then start done");
        stop_test();
    end
endmodule : two_wire_master_transmitter_tb_top
`default_nettype wire
